// ==== design/pnp_next_page_tx.sv ====
// Port 2 next page transmit codeword holder and exchange sequencer
`default_nettype none

// Overview of operation
// R01: Bit 15 flags further next pages; zero marks the final page.
// R02: Bit 13 selects message (1) or unformatted (0) page; resets to 1.
// R03: Bit 12 says whether the device can comply; resets to 0.
// R04: Each sent page carries the inverse of the previous toggle.
// R05: First next page inverts bit 11 of the sent base codeword.
// R06: Reported toggle is 1 after a zero toggle, 0 after a one.
// R07: Bits 10..0 hold the code field, reset 0x001; host reads only.
// R08: Codeword is sent only after base page, held through exchange.
module pnp_next_page_tx
   import pnp_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Auto-negotiation arbitration events
   input wire logic i_an_restart,
   input wire logic i_base_done,
   input wire logic i_base_toggle,
   input wire logic i_page_ack,
   // Next page content to send
   input wire logic i_page_load,
   input wire logic i_more_pages_flag,
   input wire logic i_page_type_select,
   input wire logic i_comply_acknowledge,
   input wire logic [PNP_CODE_W-1:0] i_code,
   // Link side codeword
   output logic [PNP_WORD_W-1:0] o_tx_codeword,
   output logic o_tx_active,
   output logic o_tx_start,
   output logic o_load_ready,
   output logic o_next_pages_done,
   // Host register read
   input wire logic i_rd_en,
   input wire logic [PNP_ADDR_W-1:0] i_rd_addr,
   output logic [PNP_WORD_W-1:0] o_rd_data,
   output logic o_rd_valid,
   output logic o_rd_hit
);

   // =========================================================
   // State
   typedef struct packed {
      pnp_state_t state;
      logic [PNP_WORD_W-1:0] codeword;
      logic last_toggle;
      logic tx_active;
      logic tx_start;
      logic load_ready;
      logic pages_done;
   } pnp_core_st_t;

   // =========================================================
   // Reset images
   // Reset image of the codeword with documented field defaults
   localparam logic [PNP_WORD_W-1:0] CODEWORD_RST = pnp_pack(
      PNP_MORE_PAGES_RST, PNP_PAGE_TYPE_RST, PNP_COMPLY_RST,
      PNP_TOGGLE_RST, PNP_CODE_RST);

   // Whole core state after reset: idle, no page on the wire
   localparam pnp_core_st_t CORE_RST = '{
      state: PNP_IDLE,
      codeword: CODEWORD_RST,
      last_toggle: PNP_TOGGLE_RST,
      tx_active: 1'h0,
      tx_start: 1'h0,
      load_ready: 1'h0,
      pages_done: 1'h0
   };

   pnp_core_st_t st_reg;
   pnp_core_st_t st_next;

   // =========================================================
   // Accepted events
   // Decoded once here, read by the sequencer below
   logic base_take;
   logic load_take;
   logic ack_take;

   // An event counts only in the state that waits for it;
   // the same pulse in any other state is dropped silently
   assign base_take = i_base_done && (st_reg.state == PNP_IDLE);
   assign load_take = i_page_load && (st_reg.state == PNP_WAIT_LOAD);
   assign ack_take = i_page_ack && (st_reg.state == PNP_SENDING);

   // =========================================================
   // Field views of the page on the wire
   // Named bits of the held codeword
   logic sent_more_pages;
   logic sent_toggle;

   // Fields the sequencer reads back once the partner acknowledges
   assign sent_more_pages = st_reg.codeword[PNP_MORE_PAGES_BIT];
   assign sent_toggle = st_reg.codeword[PNP_TOGGLE_BIT];

   // =========================================================
   // Next page image
   // Candidate codeword, taken only on an accepted load
   logic [PNP_WORD_W-1:0] load_word;

   // Fields come straight from the arbitration side; the
   // toggle is formed here so no caller can get it wrong
   assign load_word = pnp_pack(
      i_more_pages_flag,
      i_page_type_select,
      i_comply_acknowledge,
      ~st_reg.last_toggle,
      i_code);

   // =========================================================
   // Exchange sequencer
   // Restart outranks every event so a torn exchange never resumes
   always_comb begin
      st_next = st_reg;
      st_next.tx_start = 1'h0;
      st_next.pages_done = 1'h0;
      if (i_an_restart) begin
         // Restart drops any exchange; the codeword keeps its last value
         // Last toggle is kept too; the next base page reseeds it
         st_next.state = PNP_IDLE;
         st_next.tx_active = 1'h0;
      end else begin
         unique case (st_reg.state)
            // Wait for the base page exchange to complete
            PNP_IDLE: begin
               // R05 seed from base toggle
               if (base_take) begin
                  st_next.last_toggle = i_base_toggle;
                  st_next.state = PNP_WAIT_LOAD;
               end
            end
            // Wait for the arbitration side to offer page content
            PNP_WAIT_LOAD: begin
               // R08 load after base page
               if (load_take) begin
                  // R01 more pages flag
                  // R02 page type select
                  // R03 comply acknowledge
                  // R04 inverted toggle
                  // R06 toggle reporting
                  // R07 code field
                  st_next.codeword = load_word;
                  st_next.tx_active = 1'h1;
                  st_next.tx_start = 1'h1;
                  st_next.state = PNP_SENDING;
               end
            end
            // Hold the page on the wire until the partner answers
            PNP_SENDING: begin
               // R08 held until acknowledged
               if (ack_take) begin
                  // R04 remember sent toggle
                  st_next.last_toggle = sent_toggle;
                  st_next.tx_active = 1'h0;
                  // R01 final page ends exchange
                  if (sent_more_pages) begin
                     st_next.state = PNP_WAIT_LOAD;
                  end else begin
                     st_next.state = PNP_IDLE;
                     st_next.pages_done = 1'h1;
                  end
               end
            end
            // Unused state code falls back to idle with nothing sent
            default: begin
               st_next.state = PNP_IDLE;
               st_next.tx_active = 1'h0;
            end
         endcase
      end
      // Ready flag follows the next state so it is registered
      // rather than decoded from the state after the edge
      st_next.load_ready = (st_next.state == PNP_WAIT_LOAD);
   end

   // State register
   // Synchronous reset restores the documented field defaults
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st_reg <= CORE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // =========================================================
   // Host read port
   // The read port keeps its own answer registers so a host
   // read never waits on the sequencer
   pnp_rd_if bus ();

   // Request and codeword to the read port
   assign bus.rd_en = i_rd_en;
   assign bus.addr = i_rd_addr;
   assign bus.codeword = st_reg.codeword;

   // Read port instance
   pnp_rd_port u_rd_port (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .bus(bus.port)
   );

   // =========================================================
   // Outputs, all from registers
   // The codeword and flags leave straight from the core state
   assign o_tx_codeword = st_reg.codeword;
   assign o_tx_active = st_reg.tx_active;
   assign o_tx_start = st_reg.tx_start;
   assign o_load_ready = st_reg.load_ready;
   assign o_next_pages_done = st_reg.pages_done;

   // Host answers come from the read port's own registers
   assign o_rd_data = bus.rd_data;
   assign o_rd_valid = bus.rd_valid;
   assign o_rd_hit = bus.rd_hit;

endmodule

`default_nettype wire

// ==== shared/pnp_pkg.sv ====
// Constants, types and helpers for the port 2 next page transmit codeword
`default_nettype none

package pnp_pkg;

   // =========================================================
   // Register map
   localparam logic [7:0] PNP_CODEWORD_ADDR = 8'hE8; // Byte address, 16 bit
   localparam int PNP_ADDR_W = 8;
   localparam int PNP_WORD_W = 16;

   // =========================================================
   // Codeword field positions
   localparam int PNP_MORE_PAGES_BIT = 15;
   localparam int PNP_RESERVED_BIT = 14;
   localparam int PNP_PAGE_TYPE_BIT = 13;
   localparam int PNP_COMPLY_BIT = 12;
   localparam int PNP_TOGGLE_BIT = 11;
   localparam int PNP_CODE_W = 11;

   // =========================================================
   // Reset values of the codeword fields
   localparam logic PNP_MORE_PAGES_RST = 1'h0;
   localparam logic PNP_PAGE_TYPE_RST = 1'h1;
   localparam logic PNP_COMPLY_RST = 1'h0;
   localparam logic PNP_TOGGLE_RST = 1'h0;
   localparam logic [PNP_CODE_W-1:0] PNP_CODE_RST = 11'h001;
   localparam logic [PNP_WORD_W-1:0] PNP_READ_IDLE = 16'h0000;

   // =========================================================
   // Exchange sequencer states
   typedef enum logic [1:0] {
      PNP_IDLE,
      PNP_WAIT_LOAD,
      PNP_SENDING
   } pnp_state_t;

   // Assemble a codeword from its fields; reserved bit reads zero
   function automatic logic [PNP_WORD_W-1:0] pnp_pack(
      input logic more_pages,
      input logic page_type,
      input logic comply,
      input logic toggle,
      input logic [PNP_CODE_W-1:0] code);
      pnp_pack = {more_pages, 1'h0, page_type, comply, toggle, code};
   endfunction

endpackage

`default_nettype wire

// ==== shared/pnp_rd_if.sv ====
// Carrier between the codeword core and its host read port
`default_nettype none

interface pnp_rd_if;
   import pnp_pkg::*;

   logic rd_en;
   logic [PNP_ADDR_W-1:0] addr;
   logic [PNP_WORD_W-1:0] codeword;
   logic [PNP_WORD_W-1:0] rd_data;
   logic rd_valid;
   logic rd_hit;

   // Core side drives the request and the held codeword
   modport core (
      output rd_en, addr, codeword,
      input rd_data, rd_valid, rd_hit
   );

   // Read port answers from the codeword
   modport port (
      input rd_en, addr, codeword,
      output rd_data, rd_valid, rd_hit
   );
endinterface

`default_nettype wire

// ==== design/pnp_rd_port.sv ====
// Host read port that decodes the codeword address and returns its value
`default_nettype none

module pnp_rd_port
   import pnp_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Core connection
   pnp_rd_if.port bus
);

   typedef struct packed {
      logic [PNP_WORD_W-1:0] rd_data;
      logic rd_valid;
      logic rd_hit;
   } pnp_port_st_t;

   pnp_port_st_t st_reg;
   pnp_port_st_t st_next;

   // =========================================================
   // Address decode; both bytes of the word map to one register
   always_comb begin
      st_next = st_reg;
      st_next.rd_valid = bus.rd_en;
      st_next.rd_hit = bus.rd_en &&
         (bus.addr[PNP_ADDR_W-1:1] == PNP_CODEWORD_ADDR[PNP_ADDR_W-1:1]);
      // R07 host read only
      st_next.rd_data = st_next.rd_hit ? bus.codeword : PNP_READ_IDLE;
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Answers come straight from the register
   assign bus.rd_data = st_reg.rd_data;
   assign bus.rd_valid = st_reg.rd_valid;
   assign bus.rd_hit = st_reg.rd_hit;

endmodule

`default_nettype wire

// ==== verif/pnp_next_page_tx_checker.sv ====
// Port assertions for the next page transmit codeword
`default_nettype none
module pnp_next_page_tx_checker
   import pnp_pkg::*;
(
   // Clock, reset and inputs
   input wire logic i_clk, i_reset, i_an_restart, i_base_done,
   input wire logic i_base_toggle, i_page_ack, i_page_load,
   input wire logic i_more_pages_flag,
   input wire logic i_page_type_select, i_comply_acknowledge, i_rd_en,
   input wire logic [PNP_CODE_W-1:0] i_code,
   input wire logic [PNP_ADDR_W-1:0] i_rd_addr,
   // Observed outputs
   input wire logic [PNP_WORD_W-1:0] o_tx_codeword, o_rd_data,
   input wire logic o_tx_active, o_tx_start, o_load_ready,
   input wire logic o_next_pages_done, o_rd_valid, o_rd_hit
);
   timeunit 1ns / 1ns;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   logic last_reg;
   logic take;
   logic hit;
   // Load taken and address decode
   assign take = i_page_load && o_load_ready && !i_an_restart;
   assign hit = i_rd_en && i_rd_addr[7:1] == 7'h74;
   // Toggle of the last exchanged codeword
   always_ff @(posedge i_clk) begin
      if (i_reset)
         last_reg <= 1'h0;
      else if (o_tx_start)
         last_reg <= o_tx_codeword[11];
      else if (i_base_done && !o_load_ready && !o_tx_active && !i_an_restart)
         last_reg <= i_base_toggle;
   end
   // ==========================================================
   // Assertions
   reset_word_a:
   assert property ($past(i_reset) |-> o_tx_codeword == 16'h2001)
      else $error("codeword not at reset value");
   load_start_a:
   assert property (take |=> o_tx_start && o_tx_active && !o_load_ready)
      else $error("taken load did not start a page");
   more_flag_a:
   assert property (take |=> o_tx_codeword[15] == $past(i_more_pages_flag))
      else $error("more pages bit wrong");
   page_type_a:
   assert property (take |=> o_tx_codeword[13] == $past(i_page_type_select))
      else $error("page type bit wrong");
   comply_bit_a:
   assert property (take |=> o_tx_codeword[12] == $past(i_comply_acknowledge))
      else $error("comply bit wrong");
   code_field_a:
   assert property (take |=> o_tx_codeword[10:0] == $past(i_code))
      else $error("code field wrong");
   toggle_inv_a:
   assert property (o_tx_start |-> o_tx_codeword[11] != last_reg)
      else $error("toggle not inverted");
   hold_word_a:
   assert property (!take |=> $stable(o_tx_codeword))
      else $error("codeword moved without a load");
   read_hit_a:
   assert property (hit |=> o_rd_valid && o_rd_hit
      && o_rd_data == $past(o_tx_codeword)) else $error("read hit wrong");
   read_miss_a:
   assert property (i_rd_en && !hit |=> o_rd_valid && !o_rd_hit
      && o_rd_data == 16'h0000) else $error("read miss wrong");
   ack_end_a:
   assert property (i_page_ack && o_tx_active && !i_an_restart |=>
      !o_tx_active && o_load_ready == $past(o_tx_codeword[15])
      && o_next_pages_done != $past(o_tx_codeword[15]))
      else $error("acknowledged page did not end correctly");
   restart_idle_a:
   assert property (i_an_restart |=> !o_tx_active && !o_load_ready)
      else $error("restart did not return to idle");
   // Main scenarios
   cover property (take ##1 o_tx_start);
   cover property (o_next_pages_done);
   cover property (i_an_restart && o_tx_active);
endmodule
`default_nettype wire

// ==== verif/pnp_partner.sv ====
// Link partner model that acknowledges each sent next page
`default_nettype none
module pnp_partner (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // Device side
   input wire logic i_tx_active,
   input wire logic [3:0] i_delay,
   output logic o_page_ack
);
   timeunit 1ns / 1ns;
   logic [3:0] wait_reg;
   // Count cycles a page has been on the wire
   always_ff @(posedge i_clk)
      wait_reg <= (i_reset || !i_tx_active) ? 4'h0 : wait_reg + 4'h1;
   // Acknowledge promptly or after a stall
   assign o_page_ack = i_tx_active && wait_reg == i_delay;
endmodule
`default_nettype wire

// ==== verif/pnp_next_page_tx_bench.sv ====
// Self-checking bench for the next page transmit codeword
`default_nettype none
module pnp_next_page_tx_bench
   import pnp_pkg::*;
   ;
   timeunit 1ns / 1ns;
   logic i_clk, i_reset, i_an_restart, i_base_done, i_base_toggle;
   logic i_page_ack, i_page_load, i_more_pages_flag, i_page_type_select;
   logic i_comply_acknowledge, i_rd_en, o_tx_active, o_tx_start;
   logic o_load_ready, o_next_pages_done, o_rd_valid, o_rd_hit;
   logic [PNP_CODE_W-1:0] i_code;
   logic [PNP_ADDR_W-1:0] i_rd_addr;
   logic [PNP_WORD_W-1:0] o_tx_codeword, o_rd_data;
   logic [3:0] ack_delay;
   int errors = 0;
   int n_checks = 0;
   pnp_next_page_tx dut (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_an_restart(i_an_restart),
      .i_base_done(i_base_done),
      .i_base_toggle(i_base_toggle),
      .i_page_ack(i_page_ack),
      .i_page_load(i_page_load),
      .i_more_pages_flag(i_more_pages_flag),
      .i_page_type_select(i_page_type_select),
      .i_comply_acknowledge(i_comply_acknowledge),
      .i_code(i_code),
      .o_tx_codeword(o_tx_codeword),
      .o_tx_active(o_tx_active),
      .o_tx_start(o_tx_start),
      .o_load_ready(o_load_ready),
      .o_next_pages_done(o_next_pages_done),
      .i_rd_en(i_rd_en),
      .i_rd_addr(i_rd_addr),
      .o_rd_data(o_rd_data),
      .o_rd_valid(o_rd_valid),
      .o_rd_hit(o_rd_hit));
   pnp_partner peer (.i_clk(i_clk), .i_reset(i_reset),
      .i_tx_active(o_tx_active), .i_delay(ack_delay),
      .o_page_ack(i_page_ack));
   // Compare a result word
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick();
      @(posedge i_clk);
      #1;
   endtask
   function automatic logic [15:0] word(input logic m,
      input logic [10:0] c, input logic t);
      return {m, 1'h0, ~c[0], c[1], t, c};
   endfunction
   task automatic rd(input logic [7:0] a, input logic [15:0] e,
      input logic h);
      i_rd_en = 1'h1;
      i_rd_addr = a;
      tick();
      i_rd_en = 1'h0;
      chk({14'h0, o_rd_valid, o_rd_hit}, {14'h0, 1'h1, h});
      chk(o_rd_data, e);
      tick();
   endtask
   task automatic base(input logic t);
      i_base_done = 1'h1;
      i_base_toggle = t;
      tick();
      i_base_done = 1'h0;
   endtask
   task automatic load(input logic m, input logic [10:0] c, input logic t);
      int n = 0;
      while (o_load_ready !== 1'h1 && n < 30) begin
         tick();
         n++;
      end
      chk({15'h0, o_load_ready}, 16'h1);
      i_more_pages_flag = m;
      i_page_type_select = ~c[0];
      i_comply_acknowledge = c[1];
      i_code = c;
      i_page_load = 1'h1;
      tick();
      i_page_load = 1'h0;
      chk(o_tx_codeword, word(m, c, t));
      chk({15'h0, o_tx_start}, 16'h1);
   endtask
   // Reset values and address decode
   task automatic t_reset();
      rd(8'hE8, 16'h2001, 1'h1);
      rd(8'hE9, 16'h2001, 1'h1);
      rd(8'hE7, 16'h0000, 1'h0);
   endtask
   // Two page exchange, back to back or with a stalling partner
   task automatic t_exchange(input logic t, input logic [3:0] d);
      int n = 0;
      ack_delay = d;
      base(t);
      load(1'h1, 11'h2A5, ~t);
      load(1'h0, 11'h15A, t);
      while (o_next_pages_done !== 1'h1 && n < 30) begin
         tick();
         n++;
      end
      chk({15'h0, o_next_pages_done}, 16'h1);
      rd(8'hE8, word(1'h0, 11'h15A, t), 1'h1);
   endtask
   // Abort mid-page, then a refused load
   task automatic t_restart();
      ack_delay = 4'hF;
      base(1'h1);
      load(1'h1, 11'h7FF, 1'h0);
      i_an_restart = 1'h1;
      tick();
      i_an_restart = 1'h0;
      chk({14'h0, o_tx_active, o_load_ready}, 16'h0);
      i_code = 11'h000;
      i_page_load = 1'h1;
      tick();
      i_page_load = 1'h0;
      rd(8'hE8, word(1'h1, 11'h7FF, 1'h0), 1'h1);
   endtask
   task automatic tally_and_finish();
      if (errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      i_clk = 1'h0;
      forever #5 i_clk = ~i_clk;
   end
   // Watchdog well beyond the expected run
   initial begin
      #20000;
      errors++;
      tally_and_finish();
   end
   initial begin
      {i_an_restart, i_base_done, i_base_toggle, i_page_load} = 4'h0;
      {i_more_pages_flag, i_page_type_select, i_comply_acknowledge} = 3'h0;
      {i_rd_en, i_rd_addr, i_code, ack_delay} = 24'h0;
      i_reset = 1'h1;
      repeat (12) @(posedge i_clk);
      #1;
      i_reset = 1'h0;
      t_reset();
      t_exchange(1'h0, 4'h0);
      t_exchange(1'h1, 4'h3);
      t_restart();
      // Mid-run reset must restore the field defaults
      i_reset = 1'h1;
      tick();
      tick();
      i_reset = 1'h0;
      t_reset();
      tally_and_finish();
   end
endmodule
bind pnp_next_page_tx pnp_next_page_tx_checker chk_i (
   .i_clk(i_clk),
   .i_reset(i_reset),
   .i_an_restart(i_an_restart),
   .i_base_done(i_base_done),
   .i_base_toggle(i_base_toggle),
   .i_page_ack(i_page_ack),
   .i_page_load(i_page_load),
   .i_more_pages_flag(i_more_pages_flag),
   .i_page_type_select(i_page_type_select),
   .i_comply_acknowledge(i_comply_acknowledge),
   .i_rd_en(i_rd_en),
   .i_code(i_code),
   .i_rd_addr(i_rd_addr),
   .o_tx_codeword(o_tx_codeword),
   .o_rd_data(o_rd_data),
   .o_tx_active(o_tx_active),
   .o_tx_start(o_tx_start),
   .o_load_ready(o_load_ready),
   .o_next_pages_done(o_next_pages_done),
   .o_rd_valid(o_rd_valid),
   .o_rd_hit(o_rd_hit));
`default_nettype wire
